// file: rtl/tcc_pkg.sv
package tcc_pkg;

	// ****************************************************************
	// Register map (byte addresses)
	// ****************************************************************
	localparam logic [7:0]  OFF_SYS_CTRL  = 8'h00;
	localparam logic [7:0]  OFF_SEQ_STAT  = 8'h04;

	// ****************************************************************
	// System control word fields
	// ****************************************************************
	localparam int          CMD_LSB       = 0;
	localparam int          CMD_MSB       = 2;
	localparam int          START_SEND_B  = 3;
	localparam int          RSVD_LO_B     = 4;
	localparam int          PAT_LONG_B    = 5;
	localparam int          CIPHER_B      = 6;
	localparam int          RSVD_HI_B     = 7;
	localparam int          SOFT_RESET_B  = 8;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [2:0]  CMD_RESET     = 3'h1;
	localparam logic        START_RESET   = 1'b0;
	localparam logic        PAT_RESET     = 1'b0;
	localparam logic        CIPHER_RESET  = 1'b0;
	localparam logic [14:0] PRBS_SEED     = 15'h7FFF;

	// ****************************************************************
	// Command codes
	// ****************************************************************
	localparam logic [2:0]  CMD_HALT      = 3'h0;
	localparam logic [2:0]  CMD_TRANSCEIVE = 3'h3;
	localparam logic [2:0]  CMD_PRESERVE  = 3'h4;
	localparam logic [2:0]  CMD_LOOPBACK  = 3'h5;
	localparam logic [2:0]  CMD_PATTERN   = 3'h6;

	// ****************************************************************
	// Status register fields
	// ****************************************************************
	localparam int          STAT_INIT_B   = 8;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int          CLK_PERIOD_NS = 50;
	localparam int          SRST_HOLD_NS  = 1000;
	localparam int          SRST_HOLD_CYC = (SRST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ****************************************************************
	// Sequencer states
	// ****************************************************************
	typedef enum logic [5:0] {
		ST_IDLE    = 6'h01,
		ST_WAIT_TX = 6'h02,
		ST_TX      = 6'h04,
		ST_RX      = 6'h08,
		ST_LOOP    = 6'h10,
		ST_PATTERN = 6'h20
	} tcc_state_t;

	// Transmitter is driven in these states
	function automatic logic tcc_tx_active(input tcc_state_t s);
		return (s == ST_TX) || (s == ST_LOOP) || (s == ST_PATTERN);
	endfunction

	// Receiver is open in these states
	function automatic logic tcc_rx_active(input tcc_state_t s);
		return (s == ST_RX) || (s == ST_LOOP);
	endfunction

endpackage

// file: rtl/tcc_ctrl_if.sv
`timescale 1ns/1ns
interface tcc_ctrl_if;
	logic prbs_run;
	logic prbs_long;
	logic prbs_bit;
	logic srst_fire;
	logic srst_hold;

	modport ctrl (output prbs_run, output prbs_long, output srst_fire, input prbs_bit, input srst_hold);
	modport prbs (input prbs_run, input prbs_long, output prbs_bit);
	modport rst  (input srst_fire, output srst_hold);
endinterface

// file: rtl/tcc_prbs.sv
`timescale 1ns/1ns
module tcc_prbs (
	// Clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// Control
	tcc_ctrl_if.prbs  ctl
);

	typedef struct packed {
		logic [14:0] lfsr;
		logic        bit_out;
	} tcc_prbs_st_t;

	tcc_prbs_st_t st_q;
	tcc_prbs_st_t st_d;
	logic         fb;

	always_comb begin
		st_d = st_q;
		fb   = ctl.prbs_long ? (st_q.lfsr[14] ^ st_q.lfsr[13]) : (st_q.lfsr[8] ^ st_q.lfsr[4]);
		if (ctl.prbs_run) begin
			st_d.lfsr    = {st_q.lfsr[13:0], fb};
			st_d.bit_out = fb;
		end else begin
			// Restart from the seed so each run begins identically
			st_d.lfsr    = tcc_pkg::PRBS_SEED;
			st_d.bit_out = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_q <= '{lfsr: tcc_pkg::PRBS_SEED, bit_out: 1'b0};
		end else begin
			st_q <= st_d;
		end
	end

	assign ctl.prbs_bit = st_q.bit_out;

endmodule

// file: rtl/tcc_soft_reset.sv
`timescale 1ns/1ns
module tcc_soft_reset (
	// Clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// Control
	tcc_ctrl_if.rst   ctl
);

	typedef struct packed {
		logic [7:0] count;
		logic       hold;
	} tcc_srst_st_t;

	tcc_srst_st_t st_q;
	tcc_srst_st_t st_d;

	always_comb begin
		st_d = st_q;
		if (ctl.srst_fire) begin
			st_d.count = 8'(tcc_pkg::SRST_HOLD_CYC);
		end else if (st_q.count != 8'h00) begin
			st_d.count = st_q.count - 8'h01;
		end
		st_d.hold = ctl.srst_fire || (st_q.count > 8'h01);
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_q <= '{count: 8'h00, hold: 1'b0};
		end else begin
			st_q <= st_d;
		end
	end

	assign ctl.srst_hold = st_q.hold;

endmodule

// file: rtl/tcc_transceive_command_control.sv
// The implementer's own choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ns
module tcc_transceive_command_control (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Frontend status
	input  wire logic        initiator,
	input  wire logic        tx_done,
	input  wire logic        rx_done,
	// Frontend control
	output logic             tx_enable,
	output logic             rx_enable,
	output logic             frontend_idle,
	output logic             abort_pulse,
	output logic             cipher_enable,
	output logic             pattern_length_select,
	output logic             pattern_bit,
	output logic             device_reset
);

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic                ack;
		logic [31:0]         rdata;
		logic [2:0]          cmd;
		logic                start_send;
		logic                pat_long;
		logic                cipher;
		tcc_pkg::tcc_state_t state;
		logic                tx_en;
		logic                rx_en;
		logic                idle;
		logic                abort;
		logic                prbs_run;
		logic                srst_fire;
	} tcc_main_st_t;

	localparam tcc_main_st_t ST_RESET = '{
		ack:        1'b0,
		rdata:      32'h0000_0000,
		cmd:        tcc_pkg::CMD_RESET,
		start_send: tcc_pkg::START_RESET,
		pat_long:   tcc_pkg::PAT_RESET,
		cipher:     tcc_pkg::CIPHER_RESET,
		state:      tcc_pkg::ST_IDLE,
		tx_en:      1'b0,
		rx_en:      1'b0,
		idle:       1'b1,
		abort:      1'b0,
		prbs_run:   1'b0,
		srst_fire:  1'b0
	};

	tcc_main_st_t st_q;
	tcc_main_st_t st_d;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	tcc_ctrl_if   ctl ();

	logic        req;
	logic        wr;
	logic        wr_ctrl;
	logic [2:0]  code;
	logic [31:0] ctrl_word;
	logic [31:0] stat_word;

	// ****************************************************************
	// Submodules
	// ****************************************************************
	tcc_prbs u_prbs (
		.clk   (clk),
		.reset (reset),
		.ctl   (ctl.prbs)
	);

	tcc_soft_reset u_srst (
		.clk   (clk),
		.reset (reset),
		.ctl   (ctl.rst)
	);

	// Fed from the next state so pattern data stops on the same edge as tx_enable
	assign ctl.prbs_run  = st_d.prbs_run;
	assign ctl.prbs_long = st_d.pat_long;
	assign ctl.srst_fire = st_q.srst_fire;

	// ****************************************************************
	// Read words
	// ****************************************************************
	always_comb begin
		ctrl_word = 32'h0000_0000;
		ctrl_word[tcc_pkg::CMD_MSB:tcc_pkg::CMD_LSB] = st_q.cmd;
		ctrl_word[tcc_pkg::START_SEND_B] = st_q.start_send;
		ctrl_word[tcc_pkg::PAT_LONG_B]   = st_q.pat_long;
		ctrl_word[tcc_pkg::CIPHER_B]     = st_q.cipher;
		// Soft reset is write-only and reads zero
		ctrl_word[tcc_pkg::SOFT_RESET_B] = 1'b0;
		ctrl_word[tcc_pkg::RSVD_LO_B]    = 1'b0;
		ctrl_word[tcc_pkg::RSVD_HI_B]    = 1'b0;
	end

	always_comb begin
		stat_word = 32'h0000_0000;
		stat_word[5:0] = st_q.state;
		stat_word[tcc_pkg::STAT_INIT_B] = initiator;
	end

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		st_d = st_q;
		st_d.abort     = 1'b0;
		st_d.srst_fire = 1'b0;

		req     = wb_cyc_i && wb_stb_i;
		code    = wb_dat_i[tcc_pkg::CMD_MSB:tcc_pkg::CMD_LSB];
		// Writes land on the edge where the master sees ack
		wr      = req && st_q.ack && wb_we_i;
		wr_ctrl = wr && (wb_adr_i[7:2] == tcc_pkg::OFF_SYS_CTRL[7:2]);

		// Bus answer: one wait state, then ack for one cycle
		st_d.ack = req && !st_q.ack;
		if (req && !st_q.ack) begin
			if (wb_adr_i[7:2] == tcc_pkg::OFF_SYS_CTRL[7:2]) begin
				st_d.rdata = ctrl_word;
			end else if (wb_adr_i[7:2] == tcc_pkg::OFF_SEQ_STAT[7:2]) begin
				st_d.rdata = stat_word;
			end else begin
				// Unmapped: acknowledged, reads zero, writes dropped
				st_d.rdata = 32'h0000_0000;
			end
		end

		// Sequencer events from the frontend and the start_send bit
		case (st_q.state)
			tcc_pkg::ST_IDLE: begin
				st_d.state = tcc_pkg::ST_IDLE;
			end
			tcc_pkg::ST_WAIT_TX: begin
				if (st_q.start_send) begin
					st_d.state      = tcc_pkg::ST_TX;
					st_d.start_send = 1'b0;
				end
			end
			tcc_pkg::ST_TX: begin
				if (tx_done) begin
					st_d.state = tcc_pkg::ST_RX;
				end
			end
			tcc_pkg::ST_RX: begin
				// Loops back for the next frame instead of ending
				if (rx_done) begin
					st_d.state = tcc_pkg::ST_WAIT_TX;
				end
			end
			tcc_pkg::ST_LOOP: begin
				st_d.state = tcc_pkg::ST_LOOP;
			end
			tcc_pkg::ST_PATTERN: begin
				st_d.state = tcc_pkg::ST_PATTERN;
			end
			default: begin
				st_d.state = tcc_pkg::ST_IDLE;
			end
		endcase

		// Software write comes after the hardware clear, so a set wins
		if (wr_ctrl && wb_sel_i[0]) begin
			st_d.start_send = wb_dat_i[tcc_pkg::START_SEND_B];
			st_d.pat_long   = wb_dat_i[tcc_pkg::PAT_LONG_B];
			st_d.cipher     = wb_dat_i[tcc_pkg::CIPHER_B];
			if (code != tcc_pkg::CMD_PRESERVE) begin
				st_d.cmd = code;
				case (code)
					tcc_pkg::CMD_HALT: begin
						st_d.state = tcc_pkg::ST_IDLE;
						st_d.abort = 1'b1;
					end
					tcc_pkg::CMD_TRANSCEIVE: begin
						if (initiator) begin
							st_d.state = tcc_pkg::ST_WAIT_TX;
						end else begin
							st_d.state = tcc_pkg::ST_RX;
						end
					end
					tcc_pkg::CMD_LOOPBACK: begin
						st_d.state = tcc_pkg::ST_LOOP;
					end
					tcc_pkg::CMD_PATTERN: begin
						st_d.state = tcc_pkg::ST_PATTERN;
					end
					default: begin
						// Reserved codes are stored but run nothing
						st_d.state = tcc_pkg::ST_IDLE;
					end
				endcase
			end
		end

		// Bits above the soft reset lane are not stored anywhere
		if (wr_ctrl && wb_sel_i[1] && wb_dat_i[tcc_pkg::SOFT_RESET_B]) begin
			st_d.srst_fire = 1'b1;
		end

		// Frontend drive follows the next state so outputs are flops
		st_d.tx_en    = tcc_pkg::tcc_tx_active(st_d.state);
		st_d.rx_en    = tcc_pkg::tcc_rx_active(st_d.state);
		st_d.idle     = (st_d.state == tcc_pkg::ST_IDLE);
		st_d.prbs_run = (st_d.state == tcc_pkg::ST_PATTERN);

		// Soft reset returns everything but the bus handshake to defaults
		if (ctl.srst_hold) begin
			st_d       = ST_RESET;
			st_d.ack   = req && !st_q.ack;
			st_d.rdata = (req && !st_q.ack) ? 32'h0000_0000 : st_q.rdata;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_q <= ST_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign wb_ack_o              = st_q.ack;
	assign wb_dat_o              = st_q.rdata;
	assign tx_enable             = st_q.tx_en;
	assign rx_enable             = st_q.rx_en;
	assign frontend_idle         = st_q.idle;
	assign abort_pulse           = st_q.abort;
	assign cipher_enable         = st_q.cipher;
	assign pattern_length_select = st_q.pat_long;
	assign pattern_bit           = ctl.prbs_bit;
	assign device_reset          = ctl.srst_hold;

endmodule

// file: sim/tcc_sva.sv
`timescale 1ns/1ns
module tcc_sva (
	// Clock and reset
	input wire logic        clk,
	input wire logic        reset,
	// Bus
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic        wb_ack_o,
	// Frontend
	input wire logic        initiator,
	input wire logic        tx_enable,
	input wire logic        rx_enable,
	input wire logic        frontend_idle,
	input wire logic        abort_pulse,
	input wire logic        cipher_enable,
	input wire logic        pattern_length_select,
	input wire logic        pattern_bit,
	input wire logic        device_reset
);
	logic [5:0] hi_q;
	wire        wr  = wb_ack_o && wb_we_i && wb_adr_i[7:2] == 6'h00 && !device_reset;
	wire        wr0 = wr && wb_sel_i[0];

	// Length of the soft reset pulse seen so far
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			hi_q <= 6'h00;
		end else begin
			hi_q <= device_reset ? hi_q + 6'h01 : 6'h00;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	sequence one_pulse_s;
		abort_pulse ##1 !abort_pulse;
	endsequence

	ack_one_wait_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack not one cycle after request");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	halt_abort_a: assert property (wr0 && wb_dat_i[2:0] == 3'h0 |=> one_pulse_s)
		else $error("no abort pulse after halt");
	halt_idle_a: assert property (wr0 && wb_dat_i[2:0] == 3'h0 |=> frontend_idle && !tx_enable && !rx_enable)
		else $error("frontend not idle after halt");
	listen_first_a: assert property (wr0 && wb_dat_i[2:0] == 3'h3 && !initiator |=> rx_enable && !tx_enable)
		else $error("receiver not first");
	loop_both_a: assert property (wr0 && wb_dat_i[2:0] == 3'h5 |=> tx_enable && rx_enable)
		else $error("loopback not both ways");
	pattern_tx_a: assert property (wr0 && wb_dat_i[2:0] == 3'h6 |=> tx_enable && !rx_enable)
		else $error("pattern not sending");
	pattern_quiet_a: assert property (!tx_enable |-> !pattern_bit)
		else $error("pattern data while silent");
	length_sel_a: assert property (wr0 |=> pattern_length_select == $past(wb_dat_i[5]))
		else $error("pattern select wrong");
	cipher_sel_a: assert property (wr0 |=> cipher_enable == $past(wb_dat_i[6]))
		else $error("cipher enable wrong");
	srst_start_a: assert property (wr && wb_sel_i[1] && wb_dat_i[8] |-> ##[2:3] device_reset)
		else $error("soft reset late");
	srst_len_a: assert property ($fell(device_reset) |-> hi_q == 6'(tcc_pkg::SRST_HOLD_CYC))
		else $error("soft reset length wrong");
endmodule

bind tcc_transceive_command_control tcc_sva tcc_sva_i (
	.clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
	.initiator(initiator), .tx_enable(tx_enable), .rx_enable(rx_enable), .frontend_idle(frontend_idle),
	.abort_pulse(abort_pulse), .cipher_enable(cipher_enable), .pattern_length_select(pattern_length_select),
	.pattern_bit(pattern_bit), .device_reset(device_reset));

// file: sim/tb.sv
`timescale 1ns/1ns
module tb;
	logic        clk, reset, cyc, stb, we, init, txd, rxd;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] dat, dout, rd;
	logic        ack, tx_en, rx_en, idle, abrt, ciph, psel, pbit, drst;
	logic [2:0]  codes [3] = '{3'h1, 3'h2, 3'h7};
	int          bad_count, comparisons, cyc_n, k, ones;

	tcc_transceive_command_control tcc_transceive_command_control_i (
		.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack), .initiator(init),
		.tx_done(txd), .rx_done(rxd), .tx_enable(tx_en), .rx_enable(rx_en), .frontend_idle(idle),
		.abort_pulse(abrt), .cipher_enable(ciph), .pattern_length_select(psel),
		.pattern_bit(pbit), .device_reset(drst));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Hang guard, well above the few hundred cycles the tests need
	always @(posedge clk) begin
		cyc_n++;
		if (cyc_n == 5000) begin
			bad_count++;
			end_sim();
		end
	end

	// ****************************************************************
	// Bus and compare tasks
	// ****************************************************************
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Request held until ack is sampled, then released for a cycle
	task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		dat <= d;
		// Ends when ack is seen; with no ack, only the hang guard ends this wait
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		rd = dout;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
		bus(1'b1, a, s, d);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 4'hF, 32'h0);
		chk(rd, exp);
	endtask

	task automatic pulse(input logic t);
		if (t) txd <= 1'b1;
		else rxd <= 1'b1;
		step(1);
		txd <= 1'b0;
		rxd <= 1'b0;
		step(1);
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		reset = 1'b1;
		{cyc, stb, we, init, txd, rxd} = 6'h00;
		adr = 8'h00;
		sel = 4'h0;
		dat = 32'h0;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		rdchk(8'h00, 32'h1);
		rdchk(8'h04, 32'h1);
		chk(32'({ciph, psel, idle}), 32'h1);
		wr(8'h00, 4'hF, 32'hFFFF_FEF4);
		rdchk(8'h00, 32'h61);
		chk(32'({ciph, psel}), 32'h3);
		for (k = 0; k < 3; k++) begin
			wr(8'h00, 4'h1, 32'(codes[k]));
			rdchk(8'h00, 32'(codes[k]));
			rdchk(8'h04, 32'h1);
		end
		wr(8'h00, 4'h1, 32'h5);
		step(1);
		chk(32'({tx_en, rx_en}), 32'h3);
		rdchk(8'h04, 32'h10);
		wr(8'h00, 4'h1, 32'h26);
		ones = 0;
		repeat (64) begin
			@(posedge clk);
			ones += int'(pbit === 1'b1);
		end
		chk(32'(ones > 0 && ones < 64), 32'h1);
		rdchk(8'h04, 32'h20);
		chk(32'(psel), 32'h1);
		wr(8'h00, 4'h1, 32'h3);
		step(1);
		chk(32'({tx_en, rx_en}), 32'h1);
		init <= 1'b1;
		wr(8'h00, 4'h1, 32'h3);
		rdchk(8'h04, 32'h102);
		wr(8'h00, 4'h1, 32'hC);
		step(2);
		chk(32'({tx_en, rx_en}), 32'h2);
		pulse(1'b1);
		chk(32'({tx_en, rx_en}), 32'h1);
		pulse(1'b0);
		step(40);
		rdchk(8'h04, 32'h102);
		wr(8'h00, 4'h1, 32'h0);
		step(1);
		chk(32'(abrt), 32'h1);
		step(1);
		chk(32'({abrt, idle, tx_en, rx_en, pbit}), 32'h8);
		wr(8'h00, 4'h1, 32'h40);
		wr(8'h00, 4'h2, 32'h100);
		k = 0;
		while (drst !== 1'b1 && k < 10) begin
			step(1);
			k++;
		end
		chk(32'(drst), 32'h1);
		rdchk(8'h00, 32'h0);
		while (drst !== 1'b0 && k < 60) begin
			step(1);
			k++;
		end
		rdchk(8'h00, 32'h1);
		chk(32'(ciph), 32'h0);
		wr(8'h08, 4'hF, 32'hFFFF_FFFF);
		rdchk(8'h08, 32'h0);
		rdchk(8'h00, 32'h1);
		end_sim();
	end
endmodule
